// ===== hw/rsis_host.sv
// Purpose: host end: drives reset pin and the init write sequence
// Assumes: classic wishbone slave, link answers with ack
// Notes:
`timescale 1ns/1ps
`include "rsis_cfg.svh"
module rsis_host #(
	parameter int unsigned SETTLE_CYC = `RSIS_SETTLE_CYC,
	parameter int unsigned CAL_CYC = `RSIS_CAL_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	rsis_link_if.host link
);

	typedef struct packed {
		rsis_pkg::rsis_host_state_type state;
		logic [`RSIS_CNT_W-1:0] cnt;
		logic [3:0] step;
		logic chan_mode;
		logic [3:0] chan;
		logic busy;
		logic done;
		logic ack;
		logic [31:0] dat;
		logic pin_n;
		logic [9:0] addr;
		logic [7:0] wdata;
		logic wr;
	} rsis_host_regs_type;

	rsis_host_regs_type s;
	rsis_host_regs_type next_s;

	// ----------------------------------------
	// init write table
	// ----------------------------------------
	function automatic logic [17:0] rsis_step(input logic [3:0] n, input logic [3:0] ch);
		case (n)
			4'h0: rsis_step = {`RSIS_A_SW_RESET, `RSIS_V_SW_RESET_ALL};
			4'h1: rsis_step = {`RSIS_A_PA_CTRL2, `RSIS_V_PA_CTRL2};
			4'h2: rsis_step = {`RSIS_A_TX_STAB, `RSIS_V_TX_STAB};
			4'h3: rsis_step = {`RSIS_A_RF_CFG0, ch, `RSIS_V_RF_OPT};
			4'h4: rsis_step = {`RSIS_A_RF_CFG1, `RSIS_V_RF_CFG1};
			4'h5: rsis_step = {`RSIS_A_RF_CFG2, `RSIS_V_RF_CFG2};
			4'h6: rsis_step = {`RSIS_A_RF_CFG6, `RSIS_V_RF_CFG6};
			4'h7: rsis_step = {`RSIS_A_RF_CFG7, `RSIS_V_RF_CFG7};
			4'h8: rsis_step = {`RSIS_A_RF_CFG8, `RSIS_V_RF_CFG8};
			4'h9: rsis_step = {`RSIS_A_SLEEP_CFG1, `RSIS_V_SLEEP_CFG1};
			4'hA: rsis_step = {`RSIS_A_RF_STATE, `RSIS_V_RF_RST_ON};
			default: rsis_step = {`RSIS_A_RF_STATE, `RSIS_V_RF_RST_OFF};
		endcase
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		logic req;
		logic [17:0] op;
		req = wb_cyc_i && wb_stb_i && !s.ack;
		op = rsis_step(s.step, s.chan);
		next_s = s;
		next_s.ack = req;
		next_s.wr = 1'b0;
		// wishbone register access
		if (req && !wb_we_i)
		begin
			if (wb_adr_i == `RSIS_WB_CHAN)
				next_s.dat = {28'h000_0000, s.chan};
			else if (wb_adr_i == `RSIS_WB_STAT)
				next_s.dat = {30'h0000_0000, s.done, s.busy};
			else
				next_s.dat = 32'h0000_0000;
		end
		if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `RSIS_WB_CHAN && !s.busy)
		begin
			next_s.chan = wb_dat_i[3:0];
		end
		if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `RSIS_WB_CTRL && !s.busy)
		begin
			if (wb_dat_i[`RSIS_CTRL_HWRST])
			begin
				next_s.busy = 1'b1;
				next_s.done = 1'b0;
				next_s.state = rsis_pkg::HST_PIN_LOW;
				next_s.cnt = '0;
				next_s.pin_n = 1'b0;
			end
			else if (wb_dat_i[`RSIS_CTRL_INIT])
			begin
				next_s.busy = 1'b1;
				next_s.done = 1'b0;
				next_s.state = rsis_pkg::HST_ISSUE;
				next_s.step = 4'h0;
				next_s.chan_mode = 1'b0;
			end
			else if (wb_dat_i[`RSIS_CTRL_CHAN])
			begin
				next_s.busy = 1'b1;
				next_s.done = 1'b0;
				next_s.state = rsis_pkg::HST_ISSUE;
				next_s.step = `RSIS_STEP_CHAN;
				next_s.chan_mode = 1'b1;
			end
		end
		// sequencer
		case (s.state)
			rsis_pkg::HST_PIN_LOW:
			begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == `RSIS_PIN_LOW_CYC - 1'b1)
				begin
					next_s.pin_n = 1'b1;
					next_s.state = rsis_pkg::HST_SETTLE;
					next_s.cnt = '0;
				end
			end
			rsis_pkg::HST_SETTLE:
			begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == `RSIS_CNT_W'(SETTLE_CYC - 1))
				begin
					next_s.state = rsis_pkg::HST_ISSUE;
					next_s.step = 4'h0;
					next_s.chan_mode = 1'b0;
				end
			end
			rsis_pkg::HST_ISSUE:
			begin
				next_s.addr = op[17:8];
				next_s.wdata = op[7:0];
				next_s.wr = 1'b1;
				next_s.state = rsis_pkg::HST_WAIT_ACK;
			end
			rsis_pkg::HST_WAIT_ACK:
			begin
				if (link.ack)
				begin
					next_s.state = rsis_pkg::HST_ISSUE;
					if (s.step == `RSIS_STEP_LAST)
					begin
						next_s.state = rsis_pkg::HST_CAL;
						next_s.cnt = '0;
					end
					else if (s.chan_mode && s.step == `RSIS_STEP_CHAN)
						next_s.step = `RSIS_STEP_RF_ON;
					else
						next_s.step = s.step + 1'b1;
				end
			end
			rsis_pkg::HST_CAL:
			begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == `RSIS_CNT_W'(CAL_CYC - 1))
				begin
					next_s.state = rsis_pkg::HST_IDLE;
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
				end
			end
			default:
			begin
			end
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.pin_n <= 1'b1;
			s.busy <= 1'b1;
			s.state <= rsis_pkg::HST_SETTLE;
		end
		else
			s <= next_s;
	end

	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign link.reset_n = s.pin_n;
	assign link.addr = s.addr;
	assign link.wdata = s.wdata;
	assign link.wr = s.wr;

endmodule

// ===== hw/rsis_cfg.svh
// Purpose: constants of the reset and init sequencer
// Assumes: 100 MHz mclk
// Notes: times in their own unit, cycle counts derived except the 4-cycle pin low count
`ifndef RSIS_CFG_SVH
`define RSIS_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define RSIS_CLK_MHZ 100
`define RSIS_T_SETTLE_MS 2
`define RSIS_T_RELEASE_US 250
`define RSIS_T_CAL_US 192
`define RSIS_SETTLE_CYC (`RSIS_T_SETTLE_MS * 1000 * `RSIS_CLK_MHZ)
`define RSIS_RELEASE_CYC (`RSIS_T_RELEASE_US * `RSIS_CLK_MHZ)
`define RSIS_CAL_CYC (`RSIS_T_CAL_US * `RSIS_CLK_MHZ)
`define RSIS_PIN_LOW_CYC 18'h0_0004
`define RSIS_CNT_W 18

// ----------------------------------------
// device register map
// ----------------------------------------
`define RSIS_A_SW_RESET 10'h02A
`define RSIS_A_RF_STATE 10'h036
`define RSIS_A_PA_CTRL2 10'h018
`define RSIS_A_TX_STAB 10'h02E
`define RSIS_A_RF_CFG0 10'h200
`define RSIS_A_RF_CFG1 10'h201
`define RSIS_A_RF_CFG2 10'h202
`define RSIS_A_RF_CFG6 10'h206
`define RSIS_A_RF_CFG7 10'h207
`define RSIS_A_RF_CFG8 10'h208
`define RSIS_A_SLEEP_CFG1 10'h220
`define RSIS_B_PWR 2
`define RSIS_B_BB 1
`define RSIS_B_MAC 0
`define RSIS_B_RF_RST 2
`define RSIS_RF_STATE_MASK 8'h1F
`define RSIS_CFG_RESET 8'h00
`define RSIS_CFG_NONE 4'hF

// ----------------------------------------
// init values
// ----------------------------------------
`define RSIS_V_SW_RESET_ALL 8'h07
`define RSIS_V_PA_CTRL2 8'h98
`define RSIS_V_TX_STAB 8'h95
`define RSIS_V_RF_OPT 4'h3
`define RSIS_V_RF_CFG1 8'h01
`define RSIS_V_RF_CFG2 8'h80
`define RSIS_V_RF_CFG6 8'h90
`define RSIS_V_RF_CFG7 8'h80
`define RSIS_V_RF_CFG8 8'h10
`define RSIS_V_SLEEP_CFG1 8'h21
`define RSIS_V_RF_RST_ON 8'h04
`define RSIS_V_RF_RST_OFF 8'h00
`define RSIS_STEP_CHAN 4'h3
`define RSIS_STEP_RF_ON 4'hA
`define RSIS_STEP_LAST 4'hB

// ----------------------------------------
// host wishbone map
// ----------------------------------------
`define RSIS_WB_CTRL 8'h00
`define RSIS_WB_CHAN 8'h04
`define RSIS_WB_STAT 8'h08
`define RSIS_CTRL_INIT 0
`define RSIS_CTRL_HWRST 1
`define RSIS_CTRL_CHAN 2

`endif

// ===== hw/rsis_pkg.sv
// Purpose: types of the reset and init sequencer
// Assumes: constants in rsis_cfg.svh
// Notes: none
package rsis_pkg;
	typedef enum logic [1:0] {DEV_HOLD, DEV_RELEASE, DEV_RUN} rsis_dev_state_type;
	typedef enum logic [2:0] {
		HST_SETTLE, HST_IDLE, HST_PIN_LOW, HST_ISSUE, HST_WAIT_ACK, HST_CAL
	} rsis_host_state_type;
endpackage

// ===== hw/rsis_link_if.sv
// Purpose: reset pin and register write port between host and device
// Assumes: one clock mclk
// Notes: wr is a one-cycle request, ack a one-cycle answer
`timescale 1ns/1ps
interface rsis_link_if;
	logic reset_n;
	logic [9:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic ack;
	modport host (output reset_n, output addr, output wdata, output wr, input ack);
	modport dev (input reset_n, input addr, input wdata, input wr, output ack);
endinterface

// ===== hw/rsis_device.sv
// Purpose: device end: reset pin, release delay, software and rf resets
// Assumes: link inputs synchronous to mclk
// Notes: control registers reset to zero
`timescale 1ns/1ps
`include "rsis_cfg.svh"
module rsis_device #(
	parameter int unsigned RELEASE_CYC = `RSIS_RELEASE_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	rsis_link_if.dev link,
	output logic dev_ready,
	output logic pm_reset,
	output logic bb_reset,
	output logic mac_reset,
	output logic rf_machine_reset,
	output logic [3:0] channel
);

	typedef struct packed {
		rsis_pkg::rsis_dev_state_type state;
		logic [`RSIS_CNT_W-1:0] cnt;
		logic ready;
		logic ack;
		logic pm;
		logic bb;
		logic mac;
		logic [7:0] rf_state;
		logic [8:0][7:0] cfg;
	} rsis_dev_regs_type;

	rsis_dev_regs_type s;
	rsis_dev_regs_type next_s;

	// ----------------------------------------
	// control register decode
	// ----------------------------------------
	function automatic logic [3:0] rsis_cfg_index(input logic [9:0] a);
		if (a == `RSIS_A_PA_CTRL2) rsis_cfg_index = 4'h0;
		else if (a == `RSIS_A_TX_STAB) rsis_cfg_index = 4'h1;
		else if (a == `RSIS_A_RF_CFG0) rsis_cfg_index = 4'h2;
		else if (a == `RSIS_A_RF_CFG1) rsis_cfg_index = 4'h3;
		else if (a == `RSIS_A_RF_CFG2) rsis_cfg_index = 4'h4;
		else if (a == `RSIS_A_RF_CFG6) rsis_cfg_index = 4'h5;
		else if (a == `RSIS_A_RF_CFG7) rsis_cfg_index = 4'h6;
		else if (a == `RSIS_A_RF_CFG8) rsis_cfg_index = 4'h7;
		else if (a == `RSIS_A_SLEEP_CFG1) rsis_cfg_index = 4'h8;
		else rsis_cfg_index = `RSIS_CFG_NONE;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		logic [3:0] idx;
		idx = rsis_cfg_index(link.addr);
		next_s = s;
		next_s.ack = 1'b0;
		next_s.pm = 1'b0;
		next_s.bb = 1'b0;
		next_s.mac = 1'b0;
		case (s.state)
			rsis_pkg::DEV_HOLD:
			begin
				next_s.state = rsis_pkg::DEV_RELEASE;
				next_s.cnt = '0;
			end
			rsis_pkg::DEV_RELEASE:
			begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == `RSIS_CNT_W'(RELEASE_CYC - 1))
				begin
					next_s.state = rsis_pkg::DEV_RUN;
					next_s.ready = 1'b1;
				end
			end
			default:
			begin
				if (link.wr)
				begin
					next_s.ack = 1'b1;
					if (link.addr == `RSIS_A_SW_RESET)
					begin
						// each of bits 2 to 0 gives one pulse when set, bits never stored
						next_s.pm = link.wdata[`RSIS_B_PWR];
						next_s.bb = link.wdata[`RSIS_B_BB];
						next_s.mac = link.wdata[`RSIS_B_MAC];
						if (link.wdata[`RSIS_B_MAC])
						begin
							next_s.rf_state = `RSIS_CFG_RESET;
							next_s.cfg = '0;
						end
					end
					else if (link.addr == `RSIS_A_RF_STATE)
					begin
						next_s.rf_state = link.wdata & `RSIS_RF_STATE_MASK;
					end
					else if (idx != `RSIS_CFG_NONE)
					begin
						next_s.cfg[idx] = link.wdata;
					end
				end
			end
		endcase
		if (!link.reset_n)
		begin
			next_s = '0;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign link.ack = s.ack;
	assign dev_ready = s.ready;
	assign pm_reset = s.pm;
	assign bb_reset = s.bb;
	assign mac_reset = s.mac;
	assign rf_machine_reset = s.rf_state[`RSIS_B_RF_RST];
	assign channel = s.cfg[2][7:4];

endmodule

// ===== dv/rsis_assertions.sv
// Purpose: link checks between host and device ends
// Assumes: one clock mclk, rst_n async active low
// Notes: settle and calibration counts scaled by parameters
`timescale 1ns/1ps
module rsis_assertions #(
	parameter int unsigned SETTLE_CYC = 50,
	parameter int unsigned CAL_CYC = 20
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reset_n,
	input wire logic [9:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic ack
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [17:0] quiet;
	logic [17:0] cal;
	logic fresh;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			quiet <= 18'h0_0000;
			cal <= 18'h3_FFFF;
			fresh <= 1'b1;
		end
		else
		begin
			quiet <= !reset_n ? 18'h0_0000 : quiet + {17'h0_0000, quiet != 18'h3_FFFF};
			cal <= (wr && addr == 10'h036 && wdata == 8'h00) ? 18'h0_0000 :
				cal + {17'h0_0000, cal != 18'h3_FFFF};
			fresh <= !reset_n ? 1'b1 : (wr ? 1'b0 : fresh);
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_settle; wr |-> quiet >= SETTLE_CYC; endproperty
	a_settle: assert property (p_settle) else $error("write too soon after reset");
	property p_pin; !reset_n |-> !wr && !ack; endproperty
	a_pin: assert property (p_pin) else $error("link busy while pin low");
	property p_first; wr && fresh |-> addr == 10'h02A && wdata == 8'h07; endproperty
	a_first: assert property (p_first) else $error("first write wrong");
	property p_next; wr && addr == 10'h02A |-> ##3 wr && addr == 10'h018 && wdata == 8'h98; endproperty
	a_next: assert property (p_next) else $error("second write wrong");
	property p_rf; wr && addr == 10'h036 && wdata == 8'h04 |-> ##3 wr && wdata == 8'h00; endproperty
	a_rf: assert property (p_rf) else $error("rf reset not cleared");
	property p_cal; wr |-> cal >= CAL_CYC; endproperty
	a_cal: assert property (p_cal) else $error("calibration wait cut short");
	property p_ack; wr |=> ack ##1 !ack && !wr; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after write");
	property p_chan; wr && addr == 10'h200 |-> ##[3:21] wr && addr == 10'h036; endproperty
	a_chan: assert property (p_chan) else $error("no rf reset after channel");
	property p_opt; wr && addr == 10'h200 |-> wdata[3:0] == 4'h3; endproperty
	a_opt: assert property (p_opt) else $error("optimization field wrong");
	c_init: cover property (wr && addr == 10'h02A);
	c_chan: cover property (wr && addr == 10'h200 && wdata != 8'h03);
	c_pin: cover property ($fell(reset_n));
endmodule

// ===== dv/reset_and_init_sequencer_tb.sv
// Purpose: self-checking bench of host and device ends
// Assumes: short settle, release and calibration counts
// Notes: link writes recorded and compared in order
`timescale 1ns/1ps
module reset_and_init_sequencer_tb;
	logic mclk, rst_n, cyc, stb, we, ack, rdy, pm, bb, mac, rfr, full;
	logic [7:0] adr;
	logic [31:0] dat, rdo, rdat, seed, ctl;
	logic [3:0] chan, c, prev, sel, wsel;
	int err_total, samples_checked, pulses, rel;
	logic [9:0] wa[$];
	logic [7:0] wd[$];
	logic [3:0] wc[$];
	rsis_link_if rsis_link_if_inst();
	rsis_host #(.SETTLE_CYC(50), .CAL_CYC(20)) rsis_host_inst (.mclk(mclk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(sel), .wb_dat_o(rdo), .wb_ack_o(ack), .link(rsis_link_if_inst));
	rsis_device #(.RELEASE_CYC(20)) rsis_device_inst (.mclk(mclk), .rst_n(rst_n),
		.link(rsis_link_if_inst), .dev_ready(rdy), .pm_reset(pm), .bb_reset(bb),
		.mac_reset(mac), .rf_machine_reset(rfr), .channel(chan));
	rsis_assertions #(.SETTLE_CYC(50), .CAL_CYC(20)) rsis_assertions_inst (.mclk(mclk),
		.rst_n(rst_n), .reset_n(rsis_link_if_inst.reset_n), .addr(rsis_link_if_inst.addr),
		.wdata(rsis_link_if_inst.wdata), .wr(rsis_link_if_inst.wr), .ack(rsis_link_if_inst.ack));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		if (rsis_link_if_inst.wr === 1'b1)
		begin
			wa.push_back(rsis_link_if_inst.addr);
			wd.push_back(rsis_link_if_inst.wdata);
			wc.push_back(chan);
		end
		pulses += int'(pm === 1'b1) + 16 * int'(bb === 1'b1) + 256 * int'(mac === 1'b1)
			+ 4096 * int'(rfr === 1'b1);
		if (rst_n !== 1'b1 || rsis_link_if_inst.reset_n !== 1'b1)
			rel = 0;
		else if (rdy !== 1'b1)
			rel++;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [17:0] ew(input int k, input logic [3:0] v);
		case (k)
			0: return {10'h02A, 8'h07};
			1: return {10'h018, 8'h98};
			2: return {10'h02E, 8'h95};
			3: return {10'h200, v, 4'h3};
			4: return {10'h201, 8'h01};
			5: return {10'h202, 8'h80};
			6: return {10'h206, 8'h90};
			7: return {10'h207, 8'h80};
			8: return {10'h208, 8'h10};
			9: return {10'h220, 8'h21};
			10: return {10'h036, 8'h04};
			default: return {10'h036, 8'h00};
		endcase
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= wsel;
		i = 0;
		do
		begin
			@(posedge mclk);
			i++;
		end
		while (ack !== 1'b1 && i < 100);
		if (ack !== 1'b1)
		begin
			chk("wb_ack", 32'h0, 32'h1);
			wrap_up();
		end
		rdat = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wait_done();
		int i;
		i = 0;
		do
		begin
			wb(1'b0, 8'h08, 32'h0);
			i++;
		end
		while (rdat[0] !== 1'b0 && i < 300);
		if (rdat[0] !== 1'b0)
		begin
			chk("busy", 32'h0, 32'h1);
			wrap_up();
		end
		chk("status", 32'h2, rdat);
	endtask
	task automatic chk_seq(input logic f, input logic [3:0] v, input logic [3:0] p);
		int n;
		n = f ? 12 : 3;
		chk("count", 32'(n), 32'(wa.size()));
		for (int k = 0; k < n && k < wa.size(); k++)
			chk("write", 32'(ew(f ? k : (k == 0 ? 3 : k + 9), v)), 32'({wa[k], wd[k]}));
		if (wa.size() >= 2)
		begin
			chk("chan_first", 32'(p), 32'(wc[0]));
			chk("chan_second", 32'(f ? 4'h0 : v), 32'(wc[1]));
		end
		chk("chan_end", 32'(v), 32'(chan));
		chk("pulses", f ? 32'h3111 : 32'h3000, 32'(pulses));
		chk("rf_level", 32'h0, 32'(rfr));
		wa.delete();
		wd.delete();
		wc.delete();
		pulses = 0;
	endtask
	initial
	begin
		seed = 32'h0000_E971;
		wsel = 4'h1;
		{rst_n, cyc, stb, we, sel, adr, dat, pulses, rel, err_total, samples_checked} = '0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk("ready_por", 32'h0, 32'(rdy));
		wait_done();
		chk_seq(1'b1, 4'h0, 4'h0);
		chk("release", 32'd21, 32'(rel));
		wb(1'b0, 8'h44, 32'h0);
		chk("unmapped", 32'h0, rdat);
		wsel = 4'hE;
		wb(1'b1, 8'h04, 32'h0000_0009);
		wsel = 4'h1;
		wb(1'b0, 8'h04, 32'h0);
		chk("chan_lane", 32'h0, rdat);
		prev = 4'h0;
		for (int r = 0; r < 6; r++)
		begin
			c = (r == 0) ? 4'hF : 4'(rnd());
			ctl = (r % 3 == 0) ? 32'h4 : ((r % 3 == 1) ? 32'h1 : 32'h2);
			full = (r % 3 != 0);
			wb(1'b1, 8'h04, {28'h000_0000, c});
			wb(1'b0, 8'h04, 32'h0);
			chk("chan_reg", {28'h000_0000, c}, rdat);
			wb(1'b1, 8'h00, ctl);
			wb(1'b1, 8'h00, 32'h4);
			wait_done();
			chk_seq(full, c, (r % 3 == 2) ? 4'h0 : prev);
			if (r % 3 == 2)
				chk("release_pin", 32'd21, 32'(rel));
			prev = c;
		end
		wb(1'b1, 8'h04, 32'h0000_0005);
		wb(1'b1, 8'h00, 32'h0000_0004);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("chan_rst", 32'h0, 32'(chan));
		chk("ready_rst", 32'h0, 32'(rdy));
		wa.delete();
		wd.delete();
		wc.delete();
		pulses = 0;
		rst_n <= 1'b1;
		wait_done();
		chk_seq(1'b1, 4'h0, 4'h0);
		wrap_up();
	end
endmodule
